//--- design/inductive_sensor_power_status_spi.sv
// power state, fine count, status and serial register access
`default_nettype none
module inductive_sensor_power_status_spi
    import ind_sensor_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // serial port
    input  wire logic chip_select_n,
    input  wire logic sclk,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdoOe_n,
    // reference clock pin
    input  wire logic ref_clock_in,
    // analog front end events
    input  wire logic sensorOsc,
    input  wire logic lossConvDone,
    input  wire logic resistance_above_flag,
    input  wire logic resistance_window_flag,
    input  wire logic inductance_above_flag,
    input  wire logic inductance_window_flag,
    // block outputs
    output logic      convEnable,
    output logic      lOnlyMode,
    output logic      fineDone,
    output logic [1:0] powerState
);
    import ind_sensor_pkg::*;

    typedef struct packed {
        logic [1:0]  csS;
        logic [1:0]  sckS;
        logic [1:0]  sdiS;
        logic [1:0]  refS;
        logic [1:0]  oscS;
        logic [1:0]  doneS;
        logic        sckLast;
        logic        refLast;
        logic        oscLast;
        logic        doneLast;
        spstate_t    sp;
        logic [2:0]  bitCnt;
        logic [7:0]  shIn;
        logic [7:0]  shOut;
        logic        rdMode;
        logic [6:0]  addr;
        logic        sdoQ;
        logic        sdoOeQ;
        pstate_t     ps;
        logic [7:0]  rangeSetup;
        logic [7:0]  extraOpts;
        logic [7:0]  powerCtl;
        logic [7:0]  ampCheck;
        logic [15:0] refCount;
        logic        oscLost;
        logic        doneN;
        logic        fineDoneSt;
        logic        fineLost;
        logic [15:0] porCnt;
        logic [15:0] wdCnt;
        logic [21:0] fineCnt;
        logic        finePulse;
        logic [2:0]  restartCnt;
        logic [3:0]  cmpS1;
        logic [3:0]  cmpS2;
        logic        convEnQ;
        logic        lOnlyQ;
        logic [1:0]  psOutQ;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // reference-clock periods per fine interval, from count and floor
    // one count step is one microsecond: sixteen reference clocks
    function automatic logic [21:0] fine_len(input logic [15:0] cnt);
        logic [21:0] l;
        l = {2'b00, cnt, 4'h0};
        if (l < 22'(FINE_MIN_REF))
            l = 22'(FINE_MIN_REF);
        return l;
    endfunction : fine_len

    function automatic logic [7:0] read_reg(input state_t s, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_RANGE_SETUP: v = s.rangeSetup;
            ADDR_EXTRA_OPTS:  v = s.extraOpts;
            ADDR_POWER_STATE: v = s.powerCtl;
            ADDR_AMP_CHECK:   v = s.ampCheck;
            ADDR_MAIN_STATUS: begin
                v[BIT_OSC_LOST]  = s.oscLost;
                v[BIT_DONE_N]    = s.doneN;
                v[BIT_RES_ABOVE] = s.cmpS2[3];
                v[BIT_RES_WIN]   = s.cmpS2[2];
                v[BIT_IND_ABOVE] = s.cmpS2[1];
                v[BIT_IND_WIN]   = s.cmpS2[0];
                v[BIT_POR]       = (s.porCnt != 16'h0000);
            end
            ADDR_REF_CNT_LO:  v = s.refCount[7:0];
            ADDR_REF_CNT_HI:  v = s.refCount[15:8];
            ADDR_FINE_STATUS: begin
                v[BIT_FINE_DONE] = s.fineDoneSt;
                v[BIT_FINE_LOST] = s.fineLost;
            end
            default:          v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    logic sckRise;
    logic sckFall;
    logic refRise;
    logic csHigh;
    logic [7:0] byteIn;
    logic writeNow;
    logic running;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.csS  = {cur_ff.csS[0], chip_select_n};
        nxt_ff.sckS = {cur_ff.sckS[0], sclk};
        nxt_ff.sdiS = {cur_ff.sdiS[0], sdi};
        nxt_ff.refS = {cur_ff.refS[0], ref_clock_in};
        nxt_ff.oscS = {cur_ff.oscS[0], sensorOsc};
        nxt_ff.doneS = {cur_ff.doneS[0], lossConvDone};
        nxt_ff.cmpS1 = {resistance_above_flag, resistance_window_flag,
                        inductance_above_flag, inductance_window_flag};
        nxt_ff.cmpS2 = cur_ff.cmpS1;
        nxt_ff.sckLast  = cur_ff.sckS[1];
        nxt_ff.refLast  = cur_ff.refS[1];
        nxt_ff.oscLast  = cur_ff.oscS[1];
        nxt_ff.doneLast = cur_ff.doneS[1];
        nxt_ff.finePulse = 1'b0;
        sckRise = cur_ff.sckS[1] & ~cur_ff.sckLast;
        sckFall = ~cur_ff.sckS[1] & cur_ff.sckLast;
        refRise = cur_ff.refS[1] & ~cur_ff.refLast;
        csHigh  = cur_ff.csS[1];
        byteIn  = {cur_ff.shIn[6:0], cur_ff.sdiS[1]};
        writeNow = 1'b0;
        running = (cur_ff.ps == ST_ACTIVE);
        if (cur_ff.porCnt != 16'h0000)
            nxt_ff.porCnt = cur_ff.porCnt - 16'h0001;

        // serial engine: mode 0, sample on rise, shift on fall
        // serial in all states
        if (csHigh) begin
            nxt_ff.sp = SP_CMD;
            nxt_ff.bitCnt = 3'h0;
            nxt_ff.sdoOeQ = 1'b1;
        end else begin
            if (sckRise) begin
                nxt_ff.shIn = byteIn;
                nxt_ff.bitCnt = cur_ff.bitCnt + 3'h1;
                if (cur_ff.bitCnt == 3'h7) begin
                    if (cur_ff.sp == SP_CMD) begin
                        nxt_ff.rdMode = byteIn[7];
                        nxt_ff.addr = byteIn[6:0];
                        nxt_ff.sp = SP_DATA;
                        nxt_ff.shOut = read_reg(cur_ff, byteIn[6:0]);
                    end else begin
                        writeNow = ~cur_ff.rdMode;
                        nxt_ff.addr = cur_ff.addr + 7'h01;
                        nxt_ff.shOut = read_reg(cur_ff, cur_ff.addr + 7'h01);
                    end
                end
            end
            if (sckFall && cur_ff.sp == SP_DATA && cur_ff.rdMode) begin
                nxt_ff.sdoOeQ = 1'b0;
                nxt_ff.sdoQ = cur_ff.shOut[7];
                nxt_ff.shOut = {cur_ff.shOut[6:0], 1'b0};
            end
        end

        if (writeNow) begin
            case (cur_ff.addr)
                ADDR_RANGE_SETUP: nxt_ff.rangeSetup = byteIn;
                ADDR_EXTRA_OPTS:  nxt_ff.extraOpts = byteIn;
                ADDR_AMP_CHECK:   nxt_ff.ampCheck = byteIn;
                ADDR_REF_CNT_LO:  nxt_ff.refCount[7:0] = byteIn;
                ADDR_REF_CNT_HI:  nxt_ff.refCount[15:8] = byteIn;
                ADDR_POWER_STATE: begin
                    nxt_ff.powerCtl = byteIn;
                    if (byteIn[1:0] == PS_ACTIVE)
                        nxt_ff.ps = ST_ACTIVE;
                    else if (byteIn[1:0] == PS_SLEEP)
                        nxt_ff.ps = ST_SLEEP;
                    else if (byteIn[1:0] == PS_SHUTDOWN
                             && cur_ff.extraOpts[BIT_SHDN_PERMIT])
                        nxt_ff.ps = ST_SHUTDOWN;
                end
                default: ;
            endcase
        end

        // watchdog on sensor oscillation edges
        // oscillation watchdog
        if (!running || (cur_ff.oscS[1] != cur_ff.oscLast))
            nxt_ff.wdCnt = 16'h0000;
        else if (cur_ff.wdCnt != 16'(WDOG_CYCLES))
            nxt_ff.wdCnt = cur_ff.wdCnt + 16'h0001;
        if (running && cur_ff.wdCnt == 16'(WDOG_CYCLES))
            nxt_ff.oscLost = 1'b1;
        else if (cur_ff.oscS[1] != cur_ff.oscLast)
            nxt_ff.oscLost = 1'b0;

        if (running && cur_ff.doneS[1] && !cur_ff.doneLast)
            nxt_ff.doneN = 1'b0;
        else if (writeNow == 1'b0 && csHigh == 1'b0 && cur_ff.sp == SP_DATA
                 && cur_ff.rdMode && cur_ff.addr == ADDR_MAIN_STATUS
                 && sckRise && cur_ff.bitCnt == 3'h7)
            nxt_ff.doneN = 1'b1;

        // own timer, not tied to loss conversion
        if (!running) begin
            nxt_ff.fineCnt = 22'h000000;
        end else if (refRise) begin
            // range set by floor and count
            if (cur_ff.fineCnt + 22'h000001 >= fine_len(cur_ff.refCount)) begin
                nxt_ff.fineCnt = 22'h000000;
                nxt_ff.finePulse = 1'b1;
                nxt_ff.fineDoneSt = 1'b1;
            end else begin
                nxt_ff.fineCnt = cur_ff.fineCnt + 22'h000001;
            end
        end
        nxt_ff.fineLost = cur_ff.oscLost;

        if (cur_ff.ps == ST_SHUTDOWN) begin
            nxt_ff.rangeSetup = RST_RANGE_SETUP;
            nxt_ff.extraOpts  = RST_EXTRA_OPTS;
            nxt_ff.powerCtl   = RST_POWER_STATE;
            nxt_ff.ampCheck   = RST_AMP_CHECK;
            nxt_ff.refCount   = {RST_REF_CNT, RST_REF_CNT};
            nxt_ff.oscLost    = 1'b0;
            nxt_ff.doneN      = 1'b1;
            nxt_ff.fineDoneSt = 1'b0;
            nxt_ff.fineLost   = 1'b0;
            nxt_ff.wdCnt      = 16'h0000;
            if (refRise)
                nxt_ff.restartCnt = cur_ff.restartCnt + 3'h1;
            if (cur_ff.restartCnt == 3'(RESTART_EDGES)) begin
                nxt_ff.ps = ST_SLEEP;
                nxt_ff.restartCnt = 3'h0;
            end
        end

        // no fine completion once conversions stop
        if (nxt_ff.ps != ST_ACTIVE)
            nxt_ff.finePulse = 1'b0;
        // registered outputs follow the next state
        nxt_ff.convEnQ = (nxt_ff.ps == ST_ACTIVE);
        nxt_ff.lOnlyQ = nxt_ff.extraOpts[BIT_L_ONLY] & nxt_ff.ampCheck[BIT_AMP_REPORT];
        nxt_ff.psOutQ = (nxt_ff.ps == ST_SHUTDOWN) ? PS_SHUTDOWN :
                        (nxt_ff.ps == ST_ACTIVE) ? PS_ACTIVE : PS_SLEEP;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
            cur_ff.ps <= ST_SLEEP;
            cur_ff.csS <= 2'b11;
            cur_ff.sdoOeQ <= 1'b1;
            cur_ff.rangeSetup <= RST_RANGE_SETUP;
            cur_ff.extraOpts <= RST_EXTRA_OPTS;
            cur_ff.powerCtl <= RST_POWER_STATE;
            cur_ff.ampCheck <= RST_AMP_CHECK;
            cur_ff.refCount <= {RST_REF_CNT, RST_REF_CNT};
            cur_ff.doneN <= 1'b1;
            cur_ff.psOutQ <= PS_SLEEP;
            cur_ff.porCnt <= 16'(POR_CYCLES);
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign sdo = cur_ff.sdoQ;
    assign sdoOe_n = cur_ff.sdoOeQ;
    assign convEnable = cur_ff.convEnQ;
    assign lOnlyMode = cur_ff.lOnlyQ;
    assign fineDone = cur_ff.finePulse;
    assign powerState = cur_ff.psOutQ;

    a_sleep_no_fine: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.ps != ST_ACTIVE) |-> !cur_ff.finePulse)
        else $error("fine conversion outside active");
    a_shdn_defaults: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.ps == ST_SHUTDOWN) |=> (cur_ff.extraOpts == RST_EXTRA_OPTS))
        else $error("registers not defaulted in shutdown");
    a_shdn_permit: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.ps != ST_SHUTDOWN) ##1 (cur_ff.ps == ST_SHUTDOWN)
        |-> $past(cur_ff.extraOpts[BIT_SHDN_PERMIT]))
        else $error("shutdown without permit");
    a_shdn_exit: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.ps == ST_SHUTDOWN) ##1 (cur_ff.ps != ST_SHUTDOWN) |-> cur_ff.ps == ST_SLEEP)
        else $error("shutdown exit not to sleep");
    a_status_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.ps == ST_SHUTDOWN) |=> !cur_ff.oscLost && cur_ff.doneN)
        else $error("status kept in shutdown");
    a_lonly_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        lOnlyMode == (cur_ff.extraOpts[0] && cur_ff.ampCheck[0]))
        else $error("l-only mode mismatch");
    a_short_write: assert property (@(posedge mclk) disable iff (!rst_n)
        csHigh && cur_ff.ps != ST_SHUTDOWN |=> $stable(cur_ff.refCount))
        else $error("write while deselected");
    a_osc_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (running && cur_ff.wdCnt == 16'(WDOG_CYCLES)) |=> cur_ff.oscLost)
        else $error("oscillation loss not flagged");

    // state, register and serial protocol checks
    a_conv_output: assert property (@(posedge mclk) disable iff (!rst_n)
        convEnable == (cur_ff.ps == ST_ACTIVE))
        else $error("conversion enable disagrees with state");
    a_sleep_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.ps == ST_SLEEP && !writeNow) |=> $stable(cur_ff.refCount))
        else $error("register changed in sleep without write");
    a_active_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (writeNow && cur_ff.addr == ADDR_POWER_STATE && byteIn[1:0] == PS_ACTIVE
         && cur_ff.ps != ST_SHUTDOWN) |=> cur_ff.ps == ST_ACTIVE)
        else $error("active write did not start conversions");
    a_por_count: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.porCnt != 16'h0000) |=> cur_ff.porCnt == $past(cur_ff.porCnt) - 16'h0001)
        else $error("power-on count did not step");
    a_cmd_decode: assert property (@(posedge mclk) disable iff (!rst_n)
        (!csHigh && sckRise && cur_ff.bitCnt == 3'h7 && cur_ff.sp == SP_CMD)
        |=> cur_ff.sp == SP_DATA && cur_ff.rdMode == $past(byteIn[7]))
        else $error("command byte not decoded");
    a_burst_step: assert property (@(posedge mclk) disable iff (!rst_n)
        (!csHigh && sckRise && cur_ff.bitCnt == 3'h7 && cur_ff.sp == SP_DATA)
        |=> cur_ff.addr == $past(cur_ff.addr) + 7'h01)
        else $error("burst address did not advance");
    a_write_commit: assert property (@(posedge mclk) disable iff (!rst_n)
        (writeNow && cur_ff.addr == ADDR_REF_CNT_LO && cur_ff.ps != ST_SHUTDOWN)
        |=> cur_ff.refCount[7:0] == $past(byteIn))
        else $error("write not committed on eighth pulse");
    a_sdo_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur_ff.sp == SP_CMD) |-> cur_ff.sdoOeQ)
        else $error("data output enabled outside read data");
endmodule : inductive_sensor_power_status_spi
`default_nettype wire

//--- design/ind_sensor_pkg.sv
// constants for the inductive sensor control block
`default_nettype none
package ind_sensor_pkg;
    localparam logic [6:0] ADDR_RANGE_SETUP  = 7'h01;
    localparam logic [6:0] ADDR_EXTRA_OPTS   = 7'h05;
    localparam logic [6:0] ADDR_POWER_STATE  = 7'h0b;
    localparam logic [6:0] ADDR_AMP_CHECK    = 7'h0c;
    localparam logic [6:0] ADDR_MAIN_STATUS  = 7'h20;
    localparam logic [6:0] ADDR_REF_CNT_LO   = 7'h30;
    localparam logic [6:0] ADDR_REF_CNT_HI   = 7'h31;
    localparam logic [6:0] ADDR_FINE_STATUS  = 7'h3b;
    localparam logic [6:0] ADDR_LAST         = 7'h3f;
    localparam logic [7:0] RST_RANGE_SETUP   = 8'h07;
    localparam logic [7:0] RST_EXTRA_OPTS    = 8'h00;
    localparam logic [7:0] RST_POWER_STATE   = 8'h01;
    localparam logic [7:0] RST_AMP_CHECK     = 8'h00;
    localparam logic [7:0] RST_REF_CNT       = 8'h00;
    // field positions
    localparam int BIT_L_ONLY      = 0;
    localparam int BIT_SHDN_PERMIT = 1;
    localparam int BIT_AMP_REPORT  = 0;
    localparam int BIT_OSC_LOST    = 7;
    localparam int BIT_DONE_N      = 6;
    localparam int BIT_RES_ABOVE   = 5;
    localparam int BIT_RES_WIN     = 4;
    localparam int BIT_IND_ABOVE   = 3;
    localparam int BIT_IND_WIN     = 2;
    localparam int BIT_POR         = 0;
    localparam int BIT_FINE_DONE   = 0;
    localparam int BIT_FINE_LOST   = 1;
    localparam logic [1:0] PS_ACTIVE   = 2'b00;
    localparam logic [1:0] PS_SLEEP    = 2'b01;
    localparam logic [1:0] PS_SHUTDOWN = 2'b10;
    // timing
    localparam int MCLK_MHZ        = 250;
    localparam int POR_NS          = 1000;
    localparam int POR_CYCLES      = (POR_NS * MCLK_MHZ + 999) / 1000;
    localparam int WDOG_NS         = 2000;
    localparam int WDOG_CYCLES     = (WDOG_NS * MCLK_MHZ) / 1000;
    // least fine interval 5.44 us expressed in reference clocks at 16 MHz
    localparam int FINE_MIN_REF    = 87;
    localparam int RESTART_EDGES   = 4;
    typedef enum logic [1:0] {ST_SLEEP, ST_ACTIVE, ST_SHUTDOWN} pstate_t;
    typedef enum logic [1:0] {SP_CMD, SP_DATA} spstate_t;
endpackage : ind_sensor_pkg
`default_nettype wire

//--- test/spi_host_model.sv
// serial host model that drives the register port
`default_nettype none
module spi_host_model (
    // pacing clock
    input  wire logic mclk,
    // serial lines
    input  wire logic sdo,
    output logic      chip_select_n,
    output logic      sclk,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chip_select_n = 1'b1;
        sclk          = 1'b0;
        sdi           = 1'b0;
    end

    task automatic half();
        repeat (6) @(negedge mclk);
    endtask : half

    task automatic access(input logic rd, input logic [6:0] addr, input int nBytes,
                          input int lastBits, input logic [7:0] wd [4],
                          output logic [7:0] rv [4]);
        logic [7:0] tx;
        int         nb;
        chip_select_n = 1'b0;
        half();
        for (int b = 0; b <= nBytes; b++) begin
            tx = (b == 0) ? {rd, addr} : wd[b-1];
            nb = (b == nBytes) ? lastBits : 8;
            if (b > 0) rv[b-1] = 8'h00;
            for (int i = 7; i > 7 - nb; i--) begin
                sdi = tx[i];
                half();
                sclk = 1'b1;
                if (b > 0) rv[b-1][i] = sdo;
                half();
                sclk = 1'b0;
            end
        end
        half();
        chip_select_n = 1'b1;
        // released line never keeps its last level
        sdi = ~sdi;
        repeat (30) @(negedge mclk);
    endtask : access
endmodule : spi_host_model
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the sensor control block
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    import ind_sensor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk, rst_n, chip_select_n, sclk, sdi, sdo, sdoOe_n, ref_clock_in;
    logic       sensorOsc, lossConvDone, convEnable, lOnlyMode, fineDone;
    logic [3:0] cmpFlags;
    logic [1:0] powerState;
    logic       refRun, oscRun;
    logic [7:0] d;
    logic [7:0] wd [4];
    logic [7:0] rv [4];
    int         n_mismatch, checks, seed, cyc, cnt, g;

    inductive_sensor_power_status_spi inductive_sensor_power_status_spi_i (
        .mclk(mclk), .rst_n(rst_n), .chip_select_n(chip_select_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdoOe_n(sdoOe_n), .ref_clock_in(ref_clock_in),
        .sensorOsc(sensorOsc), .lossConvDone(lossConvDone),
        .resistance_above_flag(cmpFlags[3]), .resistance_window_flag(cmpFlags[2]),
        .inductance_above_flag(cmpFlags[1]), .inductance_window_flag(cmpFlags[0]),
        .convEnable(convEnable), .lOnlyMode(lOnlyMode), .fineDone(fineDone),
        .powerState(powerState));

    spi_host_model spi_host_model_i (.mclk(mclk), .sdo(sdo), .chip_select_n(chip_select_n),
        .sclk(sclk), .sdi(sdi));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // reference clock, 48 ns period, held low when stopped
    initial begin
        ref_clock_in = 1'b0;
        forever begin
            repeat (6) @(negedge mclk);
            ref_clock_in <= refRun ? ~ref_clock_in : 1'b0;
        end
    end
    initial begin
        sensorOsc = 1'b0;
        forever begin
            repeat (10) @(negedge mclk);
            sensorOsc <= oscRun ? ~sensorOsc : 1'b0;
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] statusExp(input logic lost, input logic doneN,
                                             input logic [3:0] cmp);
        return {lost, doneN, cmp, 2'b00};
    endfunction : statusExp

    function automatic int fineCycles(input int c);
        // sixteen reference clocks per step, twelve mclk per reference clock
        return ((c * 16 > FINE_MIN_REF) ? c * 16 : FINE_MIN_REF) * 12;
    endfunction : fineCycles

    task automatic wr(input logic [6:0] a, input logic [7:0] v, input int bits = 8);
        wd[0] = v;
        spi_host_model_i.access(1'b0, a, 1, bits, wd, rv);
    endtask : wr

    task automatic rd(input logic [6:0] a);
        spi_host_model_i.access(1'b1, a, 1, 8, wd, rv);
        d = rv[0];
    endtask : rd

    task automatic nextFine(input int lim);
        g = 0;
        do begin
            @(negedge mclk);
            g++;
        end while (fineDone !== 1'b1 && g < lim);
    endtask : nextFine

    task automatic chkDefaults();
        logic [6:0] a [7] = '{ADDR_RANGE_SETUP, ADDR_EXTRA_OPTS, ADDR_POWER_STATE,
                              ADDR_AMP_CHECK, ADDR_REF_CNT_LO, ADDR_REF_CNT_HI, 7'h10};
        logic [7:0] e [7] = '{RST_RANGE_SETUP, RST_EXTRA_OPTS, RST_POWER_STATE,
                              RST_AMP_CHECK, RST_REF_CNT, RST_REF_CNT, 8'h00};
        foreach (a[i]) begin
            rd(a[i]);
            `CHK(d, e[i])
        end
        `CHK(sdoOe_n, 1'b1)
    endtask : chkDefaults

    task automatic report_and_stop();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        seed = 34;
        n_mismatch = 0;
        checks = 0;
        rst_n = 1'b0;
        {lossConvDone, cmpFlags} = '0;
        refRun = 1'b1;
        oscRun = 1'b1;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        `CHK(powerState, PS_SLEEP)
        `CHK(convEnable, 1'b0)
        repeat (3) @(negedge mclk);
        rd(ADDR_MAIN_STATUS);
        `CHK(d[BIT_POR], 1'b1)
        repeat (POR_CYCLES) @(negedge mclk);
        rd(ADDR_MAIN_STATUS);
        `CHK(d[BIT_POR], 1'b0)
        chkDefaults();
        wd[0] = 8'($random(seed));
        wd[1] = 8'($random(seed));
        spi_host_model_i.access(1'b0, ADDR_REF_CNT_LO, 2, 8, wd, rv);
        spi_host_model_i.access(1'b1, ADDR_REF_CNT_LO, 2, 8, wd, rv);
        `CHK(rv[0], wd[0])
        `CHK(rv[1], wd[1])
        wr(ADDR_RANGE_SETUP, ~RST_RANGE_SETUP, 7);
        rd(ADDR_RANGE_SETUP);
        `CHK(d, RST_RANGE_SETUP)
        wr(ADDR_RANGE_SETUP, ~RST_RANGE_SETUP);
        rd(ADDR_RANGE_SETUP);
        `CHK(d, ~RST_RANGE_SETUP)
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_EXTRA_OPTS, {7'h00, k[0]});
            wr(ADDR_AMP_CHECK, {7'h00, k[1]});
            `CHK(lOnlyMode, k[0] & k[1])
        end
        // fine interval from count, above the floor
        cnt = 6 + {$random(seed)} % 5;
        wr(ADDR_REF_CNT_LO, cnt[7:0]);
        wr(ADDR_REF_CNT_HI, 8'h00);
        wr(ADDR_POWER_STATE, {6'h00, PS_ACTIVE});
        `CHK(powerState, PS_ACTIVE)
        `CHK(convEnable, 1'b1)
        nextFine(5000);
        nextFine(5000);
        `CHK(g >= fineCycles(cnt) - 24 && g <= fineCycles(cnt) + 24, 1'b1)
        cmpFlags = 4'($random(seed));
        lossConvDone = 1'b1;
        repeat (4) @(negedge mclk);
        lossConvDone = 1'b0;
        repeat (4) @(negedge mclk);
        rd(ADDR_MAIN_STATUS);
        `CHK(d, statusExp(1'b0, 1'b0, cmpFlags))
        rd(ADDR_MAIN_STATUS);
        `CHK(d, statusExp(1'b0, 1'b1, cmpFlags))
        oscRun = 1'b0;
        repeat (WDOG_CYCLES + 100) @(negedge mclk);
        rd(ADDR_MAIN_STATUS);
        `CHK(d[BIT_OSC_LOST], 1'b1)
        rd(ADDR_FINE_STATUS);
        `CHK(d[BIT_FINE_LOST], 1'b1)
        wr(ADDR_POWER_STATE, {6'h00, PS_SLEEP});
        `CHK(convEnable, 1'b0)
        nextFine(4000);
        `CHK(g, 4000)
        rd(ADDR_REF_CNT_LO);
        `CHK(d, cnt[7:0])
        // shutdown needs the permit bit; reference clock stopped so the restart count holds shutdown
        wr(ADDR_POWER_STATE, {6'h00, PS_SHUTDOWN});
        `CHK(powerState, PS_SLEEP)
        wr(ADDR_EXTRA_OPTS, 8'h02);
        refRun = 1'b0;
        repeat (20) @(negedge mclk);
        wr(ADDR_POWER_STATE, {6'h00, PS_SHUTDOWN});
        `CHK(powerState, PS_SHUTDOWN)
        `CHK(convEnable, 1'b0)
        refRun = 1'b1;
        repeat (RESTART_EDGES * 12 + 40) @(negedge mclk);
        `CHK(powerState, PS_SLEEP)
        chkDefaults();
        wr(ADDR_POWER_STATE, {6'h00, PS_ACTIVE});
        `CHK(convEnable, 1'b1)
        repeat (WDOG_CYCLES + 100) @(negedge mclk);
        rd(ADDR_MAIN_STATUS);
        `CHK(d[BIT_OSC_LOST], 1'b1)
        oscRun = 1'b1;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
